// ### logic/cme_consts.vh
// How it works
// - one 128-bit key, latched at start, keys every cipher call of a message.
// - counter blocks are 128 bits wide.
// - chain: Y0 = E(B0), Yi = E(Bi xor Yi-1) up to the last block.
// - tag is the most significant tag-length bytes of the final chain value.
// - counter blocks 0 to m, m = ceiling(payload bytes / 16).
// - every counter block 0 to m is encrypted to a keystream block.
// - payload keystream uses blocks 1 to m; block 0 is kept for the tag.
// - output stream is payload xor keystream only; tag xor block 0 goes out on the separate MIC port.
// - associated data only enters the chain, never the output stream.
// - B0 holds nonce, B1 and B2 associated data, B3 onward payload.
// - short final payload block is zero padded to 128 bits before chaining.
// - MIC length is 4, 8 or 16 bytes; other selections are refused.
// - B0 flag bits 5:3 are 001, 011 or 111 for 4, 8, 16 bytes.
// - counter block is flag byte, 13-byte nonce, 2-byte block number.
`ifndef CME_CONSTS_VH
`define CME_CONSTS_VH
`define CME_BLK_W      128
`define CME_NONCE_W    104
`define CME_PLEN_W     14
`define CME_BCNT_W     11
`define CME_OUT_W      134
`define CME_FIFO_DEPTH 16
`define CME_FIFO_AW    4
`define CME_AES_LAST   4'd10
`define CME_RCON_INIT  8'h01
`define CME_GF_POLY    8'h1b
`define CME_AFFINE_C   8'h63
`define CME_CTR_FLAGS  8'h01
`define CME_B0_FLAG_HI 2'b01
`define CME_B0_FLAG_LO 3'b001
`define CME_MIC_SEL_4  2'd0
`define CME_MIC_SEL_8  2'd1
`define CME_MIC_SEL_16 2'd2
`define CME_MIC_SEL_RSV 2'd3
`define CME_MIC_CODE_4  3'b001
`define CME_MIC_CODE_8  3'b011
`define CME_MIC_CODE_16 3'b111
`define CME_MIC_BYTES_4  5'd4
`define CME_MIC_BYTES_8  5'd8
`define CME_MIC_BYTES_16 5'd16
`endif

// ### logic/cme_fifo.v
module cme_fifo #(
  parameter W     = 134,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_r;
  reg [AW-1:0] rd_r;
  reg [AW:0]   cnt_r;
  wire         push;
  wire         pop;

  assign in_ready  = (cnt_r != DEPTH[AW:0]);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data  = mem[rd_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clk) begin
    if (push) begin
      mem[wr_r] <= in_data;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_r  <= {AW{1'b0}};
      rd_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_r <= wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= rd_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule // cme_fifo

// ### logic/cme_engine.v
`include "cme_consts.vh"

module cme_engine (
  input  wire                     CLOCK,
  input  wire                     RST_N,
  input  wire                     START,
  input  wire                     DECRYPT,
  input  wire [1:0]               MIC_SEL,
  input  wire [`CME_BLK_W-1:0]    KEY,
  input  wire [`CME_NONCE_W-1:0]  NONCE,
  input  wire [`CME_PLEN_W-1:0]   PLEN,
  input  wire [`CME_BLK_W-1:0]    AAD1,
  input  wire [`CME_BLK_W-1:0]    AAD2,
  input  wire [`CME_BLK_W-1:0]    RX_MIC,
  input  wire                     IN_VALID,
  output wire                     IN_READY,
  input  wire [`CME_BLK_W-1:0]    IN_DATA,
  output wire                     OUT_VALID,
  input  wire                     OUT_READY,
  output wire [`CME_BLK_W-1:0]    OUT_DATA,
  output wire [4:0]               OUT_BYTES,
  output wire                     OUT_LAST,
  output wire                     BUSY,
  output reg                      DONE,
  output reg  [`CME_BLK_W-1:0]    MIC,
  output reg                      MIC_FAIL
);
  localparam [3:0] ST_IDLE = 4'd0;
  localparam [3:0] ST_KICK = 4'd1;
  localparam [3:0] ST_S0   = 4'd2;
  localparam [3:0] ST_B0   = 4'd3;
  localparam [3:0] ST_B1   = 4'd4;
  localparam [3:0] ST_B2   = 4'd5;
  localparam [3:0] ST_WAIT = 4'd6;
  localparam [3:0] ST_CTR  = 4'd7;
  localparam [3:0] ST_MAC  = 4'd8;
  localparam [3:0] ST_PUSH = 4'd9;
  localparam [3:0] ST_FIN  = 4'd10;

  // field arithmetic; sbox is built from the inverse so no table is needed
  function [7:0] xt;
    input [7:0] x;
    begin
      xt = {x[6:0], 1'b0} ^ (x[7] ? `CME_GF_POLY : 8'h00);
    end
  endfunction

  function [7:0] gmul;
    input [7:0] a;
    input [7:0] b;
    reg   [7:0] p;
    reg   [7:0] x;
    integer     i;
    begin
      p = 8'h00;
      x = a;
      for (i = 0; i < 8; i = i + 1) begin
        if (b[i]) begin
          p = p ^ x;
        end
        x = xt(x);
      end
      gmul = p;
    end
  endfunction

  // x^254 is the inverse, and maps zero to zero as the sbox wants
  function [7:0] sbox;
    input [7:0] b;
    reg   [7:0] p;
    reg   [7:0] v;
    integer     i;
    begin
      p = b;
      v = 8'h01;
      for (i = 1; i < 8; i = i + 1) begin
        p = gmul(p, p);
        v = gmul(v, p);
      end
      sbox = v ^ {v[6:0], v[7]} ^ {v[5:0], v[7:6]} ^ {v[4:0], v[7:5]}
             ^ {v[3:0], v[7:4]} ^ `CME_AFFINE_C;
    end
  endfunction

  function [127:0] aes_round;
    input [127:0] st;
    input         last;
    reg   [127:0] sh;
    reg   [127:0] o;
    reg   [7:0]   a0;
    reg   [7:0]   a1;
    reg   [7:0]   a2;
    reg   [7:0]   a3;
    integer       r;
    integer       c;
    begin
      sh = 128'h0;
      o  = 128'h0;
      for (c = 0; c < 4; c = c + 1) begin
        for (r = 0; r < 4; r = r + 1) begin
          sh[127-8*(r+4*c) -: 8] = sbox(st[127-8*(r+4*((c+r)%4)) -: 8]);
        end
      end
      for (c = 0; c < 4; c = c + 1) begin
        a0 = sh[127-32*c -: 8];
        a1 = sh[119-32*c -: 8];
        a2 = sh[111-32*c -: 8];
        a3 = sh[103-32*c -: 8];
        o[127-32*c -: 8] = xt(a0) ^ xt(a1) ^ a1 ^ a2 ^ a3;
        o[119-32*c -: 8] = a0 ^ xt(a1) ^ xt(a2) ^ a2 ^ a3;
        o[111-32*c -: 8] = a0 ^ a1 ^ xt(a2) ^ xt(a3) ^ a3;
        o[103-32*c -: 8] = xt(a0) ^ a0 ^ a1 ^ a2 ^ xt(a3);
      end
      aes_round = last ? sh : o;
    end
  endfunction

  function [127:0] key_step;
    input [127:0] rk;
    input [7:0]   rc;
    reg   [31:0]  t;
    reg   [31:0]  w0;
    reg   [31:0]  w1;
    reg   [31:0]  w2;
    begin
      t  = {sbox(rk[23:16]) ^ rc, sbox(rk[15:8]), sbox(rk[7:0]), sbox(rk[31:24])};
      w0 = rk[127:96] ^ t;
      w1 = rk[95:64] ^ w0;
      w2 = rk[63:32] ^ w1;
      key_step = {w0, w1, w2, rk[31:0] ^ w2};
    end
  endfunction

  // leading n bytes set, the rest zero
  function [127:0] byte_mask;
    input [4:0] n;
    integer     i;
    begin
      byte_mask = 128'h0;
      for (i = 0; i < 16; i = i + 1) begin
        if (i < n) begin
          byte_mask[127-8*i -: 8] = 8'hff;
        end
      end
    end
  endfunction

  reg  [3:0]              state_r;
  reg  [`CME_BLK_W-1:0]   key_r;
  reg  [`CME_NONCE_W-1:0] nonce_r;
  reg  [`CME_PLEN_W-1:0]  plen_r;
  reg  [`CME_BLK_W-1:0]   aad1_r;
  reg  [`CME_BLK_W-1:0]   aad2_r;
  reg  [`CME_BLK_W-1:0]   rxmic_r;
  reg                     dec_r;
  reg  [1:0]              msel_r;
  reg  [`CME_BCNT_W-1:0]  blk_r;
  reg  [`CME_BLK_W-1:0]   s0_r;
  reg  [`CME_BLK_W-1:0]   y_r;
  reg  [`CME_BLK_W-1:0]   data_r;
  reg  [`CME_BLK_W-1:0]   out_r;
  reg  [4:0]              nb_r;
  reg                     last_r;

  reg  [127:0]            aes_st_r;
  reg  [127:0]            aes_rk_r;
  reg  [7:0]              aes_rc_r;
  reg  [3:0]              aes_rnd_r;
  reg                     aes_busy_r;
  reg                     aes_done_r;
  reg                     aes_go;
  reg  [127:0]            aes_din;
  wire [127:0]            aes_rk_nxt;

  wire [`CME_BCNT_W-1:0]  blk_m;
  wire [14:0]             rem_bytes;
  wire [4:0]              nb_now;
  wire [127:0]            pad_mask;
  wire [127:0]            ks_xor;
  wire [127:0]            plain;
  reg  [2:0]              mic_code;
  reg  [4:0]              mic_bytes;
  wire [127:0]            mic_mask;
  wire [127:0]            tag_m;
  wire                    fifo_in_ready;

  // m = ceiling(plen / 16); 11 bits reach 1024 blocks for the largest payload
  assign blk_m     = {1'b0, plen_r[13:4]} + {10'h0, (plen_r[3:0] != 4'h0)};
  assign rem_bytes = {1'b0, plen_r} - {blk_r, 4'h0};
  assign nb_now    = (rem_bytes >= 15'd16) ? 5'd16 : rem_bytes[4:0];
  assign pad_mask  = byte_mask(nb_now);
  assign ks_xor    = data_r ^ (aes_st_r & byte_mask(nb_r));
  assign plain     = dec_r ? ks_xor : data_r;
  assign mic_mask  = byte_mask(mic_bytes);
  assign tag_m     = (y_r ^ s0_r) & mic_mask;
  assign aes_rk_nxt = key_step(aes_rk_r, aes_rc_r);

  assign IN_READY  = (state_r == ST_WAIT);
  assign BUSY      = (state_r != ST_IDLE);

  always @* begin
    case (msel_r)
      `CME_MIC_SEL_4: begin
        mic_code  = `CME_MIC_CODE_4;
        mic_bytes = `CME_MIC_BYTES_4;
      end
      `CME_MIC_SEL_8: begin
        mic_code  = `CME_MIC_CODE_8;
        mic_bytes = `CME_MIC_BYTES_8;
      end
      default: begin
        mic_code  = `CME_MIC_CODE_16;
        mic_bytes = `CME_MIC_BYTES_16;
      end
    endcase
  end

  // one cipher call at a time keeps the area to a single round datapath
  always @* begin
    aes_go  = 1'b0;
    aes_din = 128'h0;
    case (state_r)
      ST_KICK: begin
        aes_go  = 1'b1;
        aes_din = {`CME_CTR_FLAGS, nonce_r, 16'h0000};
      end
      ST_S0: begin
        aes_go  = aes_done_r;
        aes_din = {`CME_B0_FLAG_HI, mic_code, `CME_B0_FLAG_LO, nonce_r,
                   2'b00, plen_r};
      end
      ST_B0: begin
        aes_go  = aes_done_r;
        aes_din = aad1_r ^ aes_st_r;
      end
      ST_B1: begin
        aes_go  = aes_done_r;
        aes_din = aad2_r ^ aes_st_r;
      end
      ST_WAIT: begin
        aes_go  = IN_VALID;
        aes_din = {`CME_CTR_FLAGS, nonce_r, 5'h00, blk_r + 1'b1};
      end
      ST_CTR: begin
        aes_go  = aes_done_r;
        aes_din = plain ^ y_r;
      end
      default: begin
        aes_go  = 1'b0;
        aes_din = 128'h0;
      end
    endcase
  end

  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      aes_st_r   <= 128'h0;
      aes_rk_r   <= 128'h0;
      aes_rc_r   <= 8'h00;
      aes_rnd_r  <= 4'h0;
      aes_busy_r <= 1'b0;
      aes_done_r <= 1'b0;
    end else begin
      aes_done_r <= 1'b0;
      if (aes_go) begin
        aes_st_r   <= aes_din ^ key_r;
        aes_rk_r   <= key_r;
        aes_rc_r   <= `CME_RCON_INIT;
        aes_rnd_r  <= 4'd1;
        aes_busy_r <= 1'b1;
      end else if (aes_busy_r) begin
        aes_st_r  <= aes_round(aes_st_r, aes_rnd_r == `CME_AES_LAST) ^ aes_rk_nxt;
        aes_rk_r  <= aes_rk_nxt;
        aes_rc_r  <= xt(aes_rc_r);
        aes_rnd_r <= aes_rnd_r + 4'd1;
        if (aes_rnd_r == `CME_AES_LAST) begin
          aes_busy_r <= 1'b0;
          aes_done_r <= 1'b1;
        end
      end
    end
  end

  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state_r  <= ST_IDLE;
      key_r    <= 128'h0;
      nonce_r  <= {`CME_NONCE_W{1'b0}};
      plen_r   <= {`CME_PLEN_W{1'b0}};
      aad1_r   <= 128'h0;
      aad2_r   <= 128'h0;
      rxmic_r  <= 128'h0;
      dec_r    <= 1'b0;
      msel_r   <= `CME_MIC_SEL_16;
      blk_r    <= {`CME_BCNT_W{1'b0}};
      s0_r     <= 128'h0;
      y_r      <= 128'h0;
      data_r   <= 128'h0;
      out_r    <= 128'h0;
      nb_r     <= 5'd0;
      last_r   <= 1'b0;
      DONE     <= 1'b0;
      MIC      <= 128'h0;
      MIC_FAIL <= 1'b0;
    end else begin
      DONE <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (START && (MIC_SEL != `CME_MIC_SEL_RSV)) begin
            key_r    <= KEY;
            nonce_r  <= NONCE;
            plen_r   <= PLEN;
            aad1_r   <= AAD1;
            aad2_r   <= AAD2;
            rxmic_r  <= RX_MIC;
            dec_r    <= DECRYPT;
            msel_r   <= MIC_SEL;
            blk_r    <= {`CME_BCNT_W{1'b0}};
            MIC_FAIL <= 1'b0;
            state_r  <= ST_KICK;
          end
        end
        ST_KICK: begin
          state_r <= ST_S0;
        end
        ST_S0: begin
          if (aes_done_r) begin
            s0_r    <= aes_st_r;
            state_r <= ST_B0;
          end
        end
        ST_B0: begin
          if (aes_done_r) begin
            state_r <= ST_B1;
          end
        end
        ST_B1: begin
          if (aes_done_r) begin
            state_r <= ST_B2;
          end
        end
        ST_B2: begin
          if (aes_done_r) begin
            y_r     <= aes_st_r;
            state_r <= (plen_r == {`CME_PLEN_W{1'b0}}) ? ST_FIN : ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (IN_VALID) begin
            data_r  <= IN_DATA & pad_mask;
            nb_r    <= nb_now;
            blk_r   <= blk_r + 1'b1;
            state_r <= ST_CTR;
          end
        end
        ST_CTR: begin
          if (aes_done_r) begin
            out_r   <= ks_xor;
            last_r  <= (blk_r == blk_m);
            state_r <= ST_MAC;
          end
        end
        ST_MAC: begin
          if (aes_done_r) begin
            y_r     <= aes_st_r;
            state_r <= ST_PUSH;
          end
        end
        ST_PUSH: begin
          if (fifo_in_ready) begin
            state_r <= last_r ? ST_FIN : ST_WAIT;
          end
        end
        ST_FIN: begin
          MIC      <= tag_m;
          MIC_FAIL <= dec_r && (tag_m != (rxmic_r & mic_mask));
          DONE     <= 1'b1;
          state_r  <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  cme_fifo #(
    .W     (`CME_OUT_W),
    .DEPTH (`CME_FIFO_DEPTH),
    .AW    (`CME_FIFO_AW)
  ) u_fifo (
    .clk       (CLOCK),
    .rst_n     (RST_N),
    .in_valid  (state_r == ST_PUSH),
    .in_ready  (fifo_in_ready),
    .in_data   ({last_r, nb_r, out_r}),
    .out_valid (OUT_VALID),
    .out_ready (OUT_READY),
    .out_data  ({OUT_LAST, OUT_BYTES, OUT_DATA})
  );
endmodule // cme_engine

// ### dv/cme_props_properties.sv
`include "cme_consts.vh"
module cme_props (
  input wire logic        CLOCK,
  input wire logic        RST_N,
  input wire logic        START,
  input wire logic        DECRYPT,
  input wire logic [1:0]  MIC_SEL,
  input wire logic        IN_VALID,
  input wire logic        IN_READY,
  input wire logic        OUT_VALID,
  input wire logic        OUT_READY,
  input wire logic [127:0] OUT_DATA,
  input wire logic [4:0]  OUT_BYTES,
  input wire logic        OUT_LAST,
  input wire logic        BUSY,
  input wire logic        DONE,
  input wire logic [127:0] MIC,
  input wire logic        MIC_FAIL
);
  timeunit 1ns;
  timeprecision 1ps;
  reg  [1:0] sel_r;
  reg        dec_r;
  wire       take = START && !BUSY && MIC_SEL != 2'd3;
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      sel_r <= 2'd0;
      dec_r <= 1'b0;
    end else if (take) begin
      sel_r <= MIC_SEL;
      dec_r <= DECRYPT;
    end
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  property p_take; take |=> BUSY; endproperty
  property p_rsv; START && !BUSY && MIC_SEL == 2'd3 |=> !BUSY; endproperty
  property p_done; DONE |=> !DONE; endproperty
  property p_mic_hold; $changed(MIC) |-> DONE; endproperty
  property p_tail;
    DONE |-> (sel_r == 2'd0 ? MIC[95:0] == 96'h0 : sel_r == 2'd1 ? MIC[63:0] == 64'h0 : 1'b1);
  endproperty
  property p_full; OUT_VALID && !OUT_LAST |-> OUT_BYTES == 5'd16; endproperty
  property p_range; OUT_VALID |-> OUT_BYTES != 5'd0 && OUT_BYTES <= 5'd16; endproperty
  property p_hold;
    OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_DATA) && $stable(OUT_LAST);
  endproperty
  property p_gap; IN_VALID && IN_READY |=> !IN_READY [*8]; endproperty
  property p_lead; take |=> !IN_READY [*8]; endproperty
  property p_clr; take |=> !MIC_FAIL; endproperty
  property p_enc; DONE && !dec_r |-> !MIC_FAIL; endproperty
  property p_idle; !BUSY |-> !IN_READY; endproperty
  a_take: assert property (p_take) else $error("start not taken");
  a_rsv: assert property (p_rsv) else $error("reserved tag length taken");
  a_done: assert property (p_done) else $error("done longer than one cycle");
  a_mic_hold: assert property (p_mic_hold) else $error("mic moved without done");
  a_tail: assert property (p_tail) else $error("mic bytes past tag length");
  a_full: assert property (p_full) else $error("short word before last");
  a_range: assert property (p_range) else $error("byte count out of range");
  a_hold: assert property (p_hold) else $error("output word not held");
  a_gap: assert property (p_gap) else $error("next block taken too soon");
  a_lead: assert property (p_lead) else $error("payload before header blocks");
  a_clr: assert property (p_clr) else $error("mic fail not cleared");
  a_enc: assert property (p_enc) else $error("mic fail in encrypt");
  a_idle: assert property (p_idle) else $error("ready while idle");
  c_fail: cover property (DONE && dec_r && MIC_FAIL);
  c_last: cover property (OUT_VALID && OUT_READY && OUT_LAST);
  c_rsv: cover property (START && !BUSY && MIC_SEL == 2'd3);
  c_stall: cover property (BUSY && OUT_VALID && !OUT_READY && !IN_READY);
endmodule // cme_props
bind cme_engine cme_props u_props (.CLOCK(CLOCK), .RST_N(RST_N), .START(START),
  .DECRYPT(DECRYPT), .MIC_SEL(MIC_SEL), .IN_VALID(IN_VALID), .IN_READY(IN_READY),
  .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY), .OUT_DATA(OUT_DATA),
  .OUT_BYTES(OUT_BYTES), .OUT_LAST(OUT_LAST), .BUSY(BUSY), .DONE(DONE), .MIC(MIC),
  .MIC_FAIL(MIC_FAIL));

// ### dv/cme_llc_model.sv
module cme_llc_model (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  int                stall,
  input  wire logic         in_ready,
  output logic              in_valid,
  output logic [127:0]      in_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [127:0] q[$];
  logic         taken;
  // take is seen on the rising edge, the bus moves on the falling one
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      taken <= 1'b0;
    else
      taken <= in_valid && in_ready;
  end
  always @(negedge clk) begin
    if (!rst_n) begin
      q.delete();
      in_valid <= 1'b0;
      in_data  <= 128'h0;
    end else if (taken) begin
      // released data is scrambled, not held
      void'(q.pop_front());
      in_valid <= 1'b0;
      in_data  <= ~in_data;
    end else if (!in_valid && q.size() > 0 && $urandom % 100 >= stall) begin
      in_valid <= 1'b1;
      in_data  <= q[0];
    end
  end
endmodule // cme_llc_model

// ### dv/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLOCK, RST_N, START, DECRYPT, OUT_READY;
  logic [1:0] MIC_SEL;
  logic [127:0] KEY, AAD1, AAD2, RX_MIC, mic_v;
  logic [103:0] NONCE;
  logic [13:0] PLEN;
  wire IN_VALID, IN_READY, OUT_VALID, OUT_LAST, BUSY, DONE, MIC_FAIL;
  wire [127:0] IN_DATA, OUT_DATA, MIC;
  wire [4:0] OUT_BYTES;
  int error_cnt, compares, cyc, stall;
  bit hold_out;
  logic fail_v;
  logic [127:0] got[$];
  logic [4:0] gbytes[$];
  logic glast[$];
  cme_engine uut (.CLOCK(CLOCK), .RST_N(RST_N), .START(START), .DECRYPT(DECRYPT),
    .MIC_SEL(MIC_SEL), .KEY(KEY), .NONCE(NONCE), .PLEN(PLEN), .AAD1(AAD1), .AAD2(AAD2),
    .RX_MIC(RX_MIC), .IN_VALID(IN_VALID), .IN_READY(IN_READY), .IN_DATA(IN_DATA),
    .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY), .OUT_DATA(OUT_DATA),
    .OUT_BYTES(OUT_BYTES), .OUT_LAST(OUT_LAST), .BUSY(BUSY), .DONE(DONE), .MIC(MIC),
    .MIC_FAIL(MIC_FAIL));
  cme_llc_model model (.clk(CLOCK), .rst_n(RST_N), .stall(stall), .in_ready(IN_READY),
    .in_valid(IN_VALID), .in_data(IN_DATA));
  task automatic conclude;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask
  function automatic int nblk(input int len);
    return (len + 15) / 16;
  endfunction
  function automatic int wbytes(input int len, input int i);
    return (len - 16 * i >= 16) ? 16 : len - 16 * i;
  endfunction
  function automatic logic [127:0] mask(input logic [127:0] b, input int n);
    return b & ({128{1'b1}} << (8 * (16 - n)));
  endfunction
  initial begin
    CLOCK = 1'b0;
    forever #10 CLOCK = ~CLOCK;
  end
  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
    if (RST_N && OUT_VALID && OUT_READY) begin
      got.push_back(OUT_DATA);
      gbytes.push_back(OUT_BYTES);
      glast.push_back(OUT_LAST);
    end
    if (cyc == 60000) begin
      error_cnt++;
      conclude();
    end
  end
  always @(negedge CLOCK)
    OUT_READY <= !hold_out && ($urandom % 4 != 0);
  task automatic run(input bit dec, input logic [1:0] sel, input int len,
                     input logic [127:0] a1, input logic [127:0] rx, input logic [127:0] din[$]);
    int n;
    got.delete();
    gbytes.delete();
    glast.delete();
    foreach (din[i]) model.q.push_back(din[i]);
    @(negedge CLOCK);
    DECRYPT = dec;
    MIC_SEL = sel;
    PLEN = 14'(len);
    AAD1 = a1;
    RX_MIC = rx;
    START = 1'b1;
    @(negedge CLOCK);
    START = 1'b0;
    n = 0;
    while (DONE !== 1'b1 && n < 4000) begin
      @(negedge CLOCK);
      n++;
    end
    chk(128'(n < 4000), 128'h1, "done missing");
    mic_v = MIC;
    fail_v = MIC_FAIL;
    n = 0;
    while (got.size() < nblk(len) && n < 200) begin
      @(negedge CLOCK);
      n++;
    end
    chk(128'(got.size()), 128'(nblk(len)), "word count");
    foreach (got[i]) begin
      chk(128'(gbytes[i]), 128'(wbytes(len, i)), "byte count");
      chk(128'(glast[i]), 128'(i == got.size() - 1), "last flag");
      chk(got[i], mask(got[i], gbytes[i]), "pad bytes");
    end
  endtask
  initial begin
    logic [127:0] p[$];
    logic [127:0] c[$];
    logic [127:0] a1, m0;
    int lens[6];
    int len;
    RST_N = 1'b0;
    START = 1'b0;
    DECRYPT = 1'b0;
    MIC_SEL = 2'd0;
    KEY = 128'h0;
    NONCE = 104'h0;
    PLEN = 14'h0;
    AAD1 = 128'h0;
    AAD2 = 128'h0;
    RX_MIC = 128'h0;
    hold_out = 1'b0;
    stall = 30;
    error_cnt = 0;
    compares = 0;
    cyc = 0;
    void'($urandom(32'h77ee178e));
    lens = '{0, 1, 16, 17, 255, 0};
    repeat (4) @(negedge CLOCK);
    RST_N = 1'b1;
    KEY = {$urandom, $urandom, $urandom, $urandom};
    NONCE = 104'({$urandom, $urandom, $urandom, $urandom});
    AAD2 = {$urandom, $urandom, $urandom, $urandom};
    for (int i = 0; i < 6; i++) begin
      len = (i < 5) ? lens[i] : $urandom_range(1, 400);
      a1 = {$urandom, $urandom, $urandom, $urandom};
      p.delete();
      repeat (nblk(len)) p.push_back({$urandom, $urandom, $urandom, $urandom});
      run(1'b0, 2'(i % 3), len, a1, 128'h0, p);
      c = got;
      m0 = mic_v;
      run(1'b1, 2'(i % 3), len, a1, m0, c);
      foreach (got[k]) chk(got[k], mask(p[k], gbytes[k]), "round trip");
      chk(mic_v, m0, "recomputed mic");
      chk(128'(fail_v), 128'h0, "false mic fail");
      run(1'b1, 2'(i % 3), len, a1, m0 ^ (128'h1 << 127), c);
      chk(128'(fail_v), 128'h1, "bad mic passed");
      run(1'b0, 2'(i % 3), len, ~a1, 128'h0, p);
      foreach (got[k]) chk(got[k], c[k], "aad in output");
      chk(128'(mic_v != m0), 128'h1, "aad not in mic");
    end
    @(negedge CLOCK);
    MIC_SEL = 2'd3;
    START = 1'b1;
    @(negedge CLOCK);
    START = 1'b0;
    repeat (3) @(negedge CLOCK);
    chk(128'(BUSY), 128'h0, "reserved taken");
    repeat (4) model.q.push_back({$urandom, $urandom, $urandom, $urandom});
    MIC_SEL = 2'd1;
    PLEN = 14'd64;
    START = 1'b1;
    @(negedge CLOCK);
    START = 1'b0;
    repeat (100) @(negedge CLOCK);
    RST_N = 1'b0;
    @(negedge CLOCK);
    chk(128'({BUSY, OUT_VALID, DONE, IN_READY}), 128'h0, "reset state");
    @(negedge CLOCK);
    RST_N = 1'b1;
    p.delete();
    repeat (19) p.push_back({$urandom, $urandom, $urandom, $urandom});
    hold_out = 1'b1;
    fork
      run(1'b0, 2'd2, 300, a1, 128'h0, p);
      begin
        repeat (900) @(negedge CLOCK);
        chk(128'({BUSY, OUT_VALID, IN_READY}), 128'h6, "fifo back pressure");
        hold_out = 1'b0;
      end
    join
    conclude();
  end
endmodule // tb
